/* File: hmsl_map.vh */
`ifndef HMSL_MAP_VH
`define HMSL_MAP_VH

// Register byte offsets on the peripheral bus
`define HMSL_A_INSTR      8'h00
`define HMSL_A_STATUS     8'h04
`define HMSL_A_FIX        8'h08
`define HMSL_A_EXC        8'h0c
`define HMSL_A_ADDR       8'h10
`define HMSL_A_GREG_BIT   7

// Status fields
`define HMSL_ST_BUSY      0
`define HMSL_ST_DONE      1
`define HMSL_ST_INVAL     2
`define HMSL_ST_ALIGN     3

// Reset values
`define HMSL_RST_WORD     32'h0000_0000
`define HMSL_RST_STATE    2'b01

// Instruction matching
`define HMSL_MASK_D       32'hfc00_0000
`define HMSL_MASK_X       32'hfc00_07fe
`define HMSL_OP_LHA       32'ha800_0000
`define HMSL_OP_LHAU      32'hac00_0000
`define HMSL_OP_LHZ       32'ha000_0000
`define HMSL_OP_LHZU      32'ha400_0000
`define HMSL_OP_LMW       32'hb800_0000
`define HMSL_OP_LHAX      32'h7c00_02ae
`define HMSL_OP_LHAUX     32'h7c00_02ee
`define HMSL_OP_LHBRX     32'h7c00_062c
`define HMSL_OP_LHZUX     32'h7c00_026e
`define HMSL_OP_LHZX      32'h7c00_022e
`define HMSL_OP_LSWI      32'h7c00_04aa
`define HMSL_OP_LSWX      32'h7c00_042a

// Counts and vectors
`define HMSL_NREGS        6'h20
`define HMSL_STR_DEF      8'h20
`define HMSL_HALF_BYTES   8'h02
`define HMSL_FIX_CNT_MSB  6
`define HMSL_DSI_VECTOR   32'h0000_0300

`endif

/* File: hmsl_load_unit.v */
// Overview of operation
// - Half algebraic update: base plus displacement
// - Algebraic half loads sign-extend bit 15
// - Update forms write address into base
// - Update form invalid: base zero or target
// - Algebraic update indexed: two registers, extend
// - Byte-reversed half load, upper bits cleared
// - Zeroing half load with displacement
// - Zeroing half update: add, zero-extend, update
// - Zeroing update indexed: add, extend, update
// - Zeroing indexed: base zero means zero
// - Load multiple fills target through 31
// - Load multiple misaligned raises alignment fault
// - Base in loaded range is invalid
// - Immediate string: count zero means 32
// - Strings pack bytes from most significant
// - Destination register number wraps modulo 32
// - Partial last string register low bytes cleared
// - Strings may raise alignment on segment cross
// - Indexed string count from exception register
// - Indexed string, zero count: target untouched
// - Indexed string target equal base/index invalid
`timescale 1ns/10ps
`include "hmsl_map.vh"

module hmsl_load_unit #(
    parameter SEG_CHECK = 1
)(
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         mem_req,
    output reg  [31:0] mem_addr,
    input  wire [31:0] mem_rdata,
    input  wire        mem_ack,
    output reg         busy
);

    localparam S_IDLE = 2'b01;
    localparam S_WAIT = 2'b10;

    reg [31:0] general_register [0:31];
    reg [1:0]  state_reg;
    reg [31:0] instr_reg;
    reg [31:0] fixed_point_exception_register;
    reg [31:0] addr_reg;
    reg [31:0] org_addr_reg;
    reg [7:0]  cnt_reg;
    reg [1:0]  idx_reg;
    reg [4:0]  dst_reg;
    reg [4:0]  base_reg;
    reg [31:0] acc_reg;
    reg        alg_reg;
    reg        zro_reg;
    reg        rev_reg;
    reg        upd_reg;
    reg        done_reg;
    reg        inval_reg;
    reg        align_reg;
    integer    k;

    // Decode straight off the write data of the starting bus write
    wire [4:0]  f_d  = pwdata[25:21];
    wire [4:0]  f_a  = pwdata[20:16];
    wire [4:0]  f_b  = pwdata[15:11];
    wire [31:0] dx   = {{16{pwdata[15]}}, pwdata[15:0]};
    wire [31:0] md   = pwdata & `HMSL_MASK_D;
    wire [31:0] mx   = pwdata & `HMSL_MASK_X;
    wire [31:0] va   = general_register[f_a];
    wire [31:0] vb   = general_register[f_b];
    wire [31:0] va0  = (f_a == 5'h00) ? `HMSL_RST_WORD : va;

    wire is_lha   = (md == `HMSL_OP_LHA);
    wire is_lhau  = (md == `HMSL_OP_LHAU);
    wire is_lhz   = (md == `HMSL_OP_LHZ);
    wire is_lhzu  = (md == `HMSL_OP_LHZU);
    wire is_lmw   = (md == `HMSL_OP_LMW);
    wire is_lhax  = (mx == `HMSL_OP_LHAX);
    wire is_lhaux = (mx == `HMSL_OP_LHAUX);
    wire is_lhbrx = (mx == `HMSL_OP_LHBRX);
    wire is_lhzux = (mx == `HMSL_OP_LHZUX);
    wire is_lhzx  = (mx == `HMSL_OP_LHZX);
    wire is_lswi  = (mx == `HMSL_OP_LSWI);
    wire is_lswx  = (mx == `HMSL_OP_LSWX);

    wire d_form = is_lha | is_lhau | is_lhz | is_lhzu | is_lmw;
    wire upd    = is_lhau | is_lhaux | is_lhzu | is_lhzux;
    wire alg    = is_lha | is_lhau | is_lhax | is_lhaux;
    wire zro    = is_lhz | is_lhzu | is_lhzux | is_lhzx;
    wire half   = alg | zro | is_lhbrx;
    wire known  = half | is_lmw | is_lswi | is_lswx;

    // Update forms use the base as is; the rest read zero for field 0
    wire [31:0] basev    = upd ? va : va0;
    wire [31:0] offs     = d_form ? dx : vb;
    wire [31:0] addr_new = is_lswi ? va0 : basev + offs;

    wire [5:0]  lmw_regs = `HMSL_NREGS - {1'b0, f_d};
    wire [7:0]  lswi_n   = (f_b == 5'h00) ? `HMSL_STR_DEF
                                          : {3'b000, f_b};
    wire [5:0]  lswi_nr  = lswi_n[7:2] + {5'h00, |lswi_n[1:0]};
    wire [4:0]  a_off    = f_a - f_d;
    wire [7:0]  fix_n    = {1'b0,
        fixed_point_exception_register[`HMSL_FIX_CNT_MSB:0]};

    reg  [7:0]  n_new;
    always @*
    begin
        n_new = `HMSL_HALF_BYTES;
        if (is_lmw)
            n_new = {lmw_regs, 2'b00};
        else if (is_lswi)
            n_new = lswi_n;
        else if (is_lswx)
            n_new = fix_n;
    end

    wire bad_upd  = upd & ((f_a == 5'h00) | (f_a == f_d));
    wire bad_lmw  = is_lmw & ((f_a == 5'h00) | (f_a >= f_d));
    wire bad_lswi = is_lswi & ((f_a == 5'h00)
                    | ({1'b0, a_off} < lswi_nr));
    wire bad_lswx = is_lswx & ((f_d == f_a) | (f_d == f_b)
                    | ((f_d == 5'h00) & (f_a == 5'h00)));
    wire bad      = ~known | bad_upd | bad_lmw | bad_lswi | bad_lswx;
    wire misal    = is_lmw & (addr_new[1:0] != 2'b00);

    // Bus decode
    wire       acc_ph  = psel & penable;
    wire       commit  = acc_ph & pready;
    wire       is_greg = paddr[`HMSL_A_GREG_BIT];
    wire [4:0] gidx    = paddr[6:2];
    wire       a_instr = (paddr == `HMSL_A_INSTR);
    wire       a_stat  = (paddr == `HMSL_A_STATUS);
    wire       a_fix   = (paddr == `HMSL_A_FIX);
    wire       a_exc   = (paddr == `HMSL_A_EXC);
    wire       a_addr  = (paddr == `HMSL_A_ADDR);
    wire       a_ok    = (paddr[1:0] == 2'b00)
                         & (is_greg | a_instr | a_stat | a_fix
                            | a_exc | a_addr);
    wire       a_ro    = pwrite & (a_stat | a_exc | a_addr);
    // Software may not disturb registers under a running load
    wire       a_busy  = pwrite & busy & (a_instr | a_fix | is_greg);
    wire       a_err   = ~a_ok | a_ro | a_busy;
    wire       wr_ok   = commit & pwrite & ~pslverr;
    wire       start   = wr_ok & a_instr & state_reg[0];

    // Byte lanes are big-endian: offset 0 is the top byte of the word
    wire [31:0] msh      = mem_rdata >> {~addr_reg[1:0], 3'b000};
    wire [31:0] acc_next = acc_reg
                           | ({24'h000000, msh[7:0]}
                              << {~idx_reg, 3'b000});
    wire [15:0] h        = acc_next[31:16];
    wire        last     = (cnt_reg == 8'h01);
    wire        half_r   = alg_reg | zro_reg | rev_reg;
    wire        full     = last | (idx_reg == 2'b11);
    wire [31:0] addr_inc = addr_reg + 32'h0000_0001;
    wire        seg_x    = (SEG_CHECK != 0) & ~half_r & ~last
                           & (addr_inc[31:28] != addr_reg[31:28]);
    wire        got      = state_reg[1] & mem_ack;

    reg [31:0] wb_data;
    always @*
    begin
        wb_data = acc_next;
        if (alg_reg)
            wb_data = {{16{h[15]}}, h};
        else if (zro_reg)
            wb_data = {16'h0000, h};
        else if (rev_reg)
            wb_data = {16'h0000, h[7:0], h[15:8]};
    end

    wire eng_we = got & (half_r ? last : full);
    wire upd_we = got & last & upd_reg;

    // Register file: bus writes only while idle, so no port clash
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (k = 0; k < 32; k = k + 1)
                general_register[k] <= `HMSL_RST_WORD;
        end
        else
        begin
            if (wr_ok & is_greg)
                general_register[gidx] <= pwdata;
            if (eng_we)
                general_register[dst_reg] <= wb_data;
            if (upd_we)
                general_register[base_reg] <= org_addr_reg;
        end
    end

    // Bus slave: one wait state, answer registered
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready                         <= 1'b0;
            pslverr                        <= 1'b0;
            prdata                         <= `HMSL_RST_WORD;
            instr_reg                      <= `HMSL_RST_WORD;
            fixed_point_exception_register <= `HMSL_RST_WORD;
        end
        else
        begin
            pready <= acc_ph & ~pready;
            if (acc_ph & ~pready)
            begin
                pslverr <= a_err;
                prdata  <= `HMSL_RST_WORD;
                if (!pwrite & a_ok)
                begin
                    if (is_greg)
                        prdata <= general_register[gidx];
                    else if (a_instr)
                        prdata <= instr_reg;
                    else if (a_stat)
                        prdata <= {28'h0000000, align_reg, inval_reg,
                                   done_reg, busy};
                    else if (a_fix)
                        prdata <= fixed_point_exception_register;
                    else if (a_exc)
                        prdata <= align_reg ? `HMSL_DSI_VECTOR
                                            : `HMSL_RST_WORD;
                    else
                        prdata <= org_addr_reg;
                end
            end
            else if (!acc_ph)
            begin
                pslverr <= 1'b0;
            end
            if (start)
                instr_reg <= pwdata;
            // Only software writes this register; loads never do
            if (wr_ok & a_fix)
                fixed_point_exception_register <= pwdata;
        end
    end

    // Load engine: one word read per byte, simple but slow
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= `HMSL_RST_STATE;
            busy         <= 1'b0;
            mem_req      <= 1'b0;
            mem_addr     <= `HMSL_RST_WORD;
            addr_reg     <= `HMSL_RST_WORD;
            org_addr_reg <= `HMSL_RST_WORD;
            cnt_reg      <= 8'h00;
            idx_reg      <= 2'b00;
            dst_reg      <= 5'h00;
            base_reg     <= 5'h00;
            acc_reg      <= `HMSL_RST_WORD;
            alg_reg      <= 1'b0;
            zro_reg      <= 1'b0;
            rev_reg      <= 1'b0;
            upd_reg      <= 1'b0;
            done_reg     <= 1'b0;
            inval_reg    <= 1'b0;
            align_reg    <= 1'b0;
        end
        else
        begin
            mem_req <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (start)
                    begin
                        done_reg     <= 1'b0;
                        inval_reg    <= bad;
                        align_reg    <= ~bad & misal;
                        org_addr_reg <= addr_new;
                        addr_reg     <= addr_new;
                        cnt_reg      <= n_new;
                        idx_reg      <= 2'b00;
                        dst_reg      <= f_d;
                        base_reg     <= f_a;
                        acc_reg      <= `HMSL_RST_WORD;
                        alg_reg      <= alg;
                        zro_reg      <= zro;
                        rev_reg      <= is_lhbrx;
                        upd_reg      <= upd;
                        // A zero count leaves the target as it was
                        if (bad | misal | (n_new == 8'h00))
                        begin
                            done_reg <= 1'b1;
                        end
                        else
                        begin
                            state_reg <= S_WAIT;
                            busy      <= 1'b1;
                            mem_req   <= 1'b1;
                            mem_addr  <= {addr_new[31:2], 2'b00};
                        end
                    end
                end
                S_WAIT:
                begin
                    if (mem_ack)
                    begin
                        acc_reg <= full ? `HMSL_RST_WORD : acc_next;
                        if (full & ~half_r)
                            dst_reg <= dst_reg + 5'h01;
                        idx_reg  <= idx_reg + 2'b01;
                        cnt_reg  <= cnt_reg - 8'h01;
                        addr_reg <= addr_inc;
                        if (last | seg_x)
                        begin
                            state_reg <= S_IDLE;
                            busy      <= 1'b0;
                            done_reg  <= 1'b1;
                            align_reg <= seg_x;
                        end
                        else
                        begin
                            mem_req  <= 1'b1;
                            mem_addr <= {addr_inc[31:2], 2'b00};
                        end
                    end
                end
                default:
                begin
                    state_reg <= S_IDLE;
                    busy      <= 1'b0;
                end
            endcase
        end
    end

endmodule // hmsl_load_unit

/* File: hmsl_load_unit_assertions.sv */
`timescale 1ns/10ps
`include "hmsl_map.vh"
module hmsl_chk (
    input wire        pclk,
    input wire        presetn,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        mem_req,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_rdata,
    input wire        mem_ack,
    input wire        busy
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Tracks the single read that may be in flight
    logic pend_reg;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            pend_reg <= 1'b0;
        else
            pend_reg <= mem_req | (pend_reg & ~mem_ack);
    property p_wait; psel && $rose(penable) |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("late ready");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_ctx; pready |-> psel && penable; endproperty
    a_ctx: assert property (p_ctx) else $error("stray ready");
    property p_req1; mem_req |=> !mem_req; endproperty
    a_req1: assert property (p_req1) else $error("long req");
    property p_one; mem_req |-> !pend_reg; endproperty
    a_one: assert property (p_one) else $error("two reads");
    property p_align; mem_req |-> mem_addr[1:0] == 2'b00; endproperty
    a_align: assert property (p_align) else $error("odd addr");
    property p_rbusy; mem_req |-> busy; endproperty
    a_rbusy: assert property (p_rbusy) else $error("idle req");
    property p_hold; !$stable(mem_addr) |-> mem_req; endproperty
    a_hold: assert property (p_hold) else $error("addr moved");
    property p_end; $fell(busy) |-> $past(mem_ack); endproperty
    a_end: assert property (p_end) else $error("early end");
    property p_start;
        $rose(busy) |-> $past(psel && pwrite && paddr == `HMSL_A_INSTR);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_ro;
        pready && pwrite && paddr == `HMSL_A_STATUS |-> pslverr;
    endproperty
    a_ro: assert property (p_ro) else $error("ro write taken");
    c_start: cover property ($rose(busy));
    c_refuse: cover property (pready && pslverr);
    c_slow: cover property (mem_req ##[4:8] mem_ack);
endmodule // hmsl_chk

bind hmsl_load_unit hmsl_chk hmsl_chk_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .busy(busy)
);

/* File: hmsl_mem_model.sv */
`timescale 1ns/10ps
module hmsl_mem_model (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         mem_req,
    input  wire  [31:0] mem_addr,
    input  wire         slow,
    output logic [31:0] mem_rdata,
    output logic        mem_ack
);
    logic [31:0] a_reg;
    logic        pend_reg;
    int          wait_cnt;
    function automatic logic [7:0] mb(input logic [31:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pend_reg <= 1'b0;
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            wait_cnt <= 0;
        end
        else
        begin
            mem_ack <= 1'b0;
            // Data is only meaningful with the ack
            mem_rdata <= ~mem_rdata;
            if (mem_req)
            begin
                pend_reg <= 1'b1;
                a_reg <= mem_addr;
                wait_cnt <= slow ? 5 : 0;
            end
            else if (pend_reg && wait_cnt != 0)
                wait_cnt <= wait_cnt - 1;
            else if (pend_reg)
            begin
                pend_reg <= 1'b0;
                mem_ack <= 1'b1;
                mem_rdata <= {mb(a_reg), mb(a_reg + 1), mb(a_reg + 2),
                              mb(a_reg + 3)};
            end
        end
endmodule // hmsl_mem_model

/* File: tb_top.sv */
`timescale 1ns/10ps
`include "hmsl_map.vh"
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[ERR] %0t got %h want %h", $time, (g), (e)); \
        end \
    end
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, mem_addr, mem_rdata;
    logic        pready, pslverr, mem_req, mem_ack, busy;
    int          failures = 0;
    int          cmp_count = 0;
    always #20 pclk = ~pclk;
    hmsl_load_unit hmsl_load_unit_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .busy(busy));
    hmsl_mem_model hmsl_mem_model_inst (
        .pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .slow(slow), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    function automatic logic [7:0] mb(input logic [31:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction
    function automatic logic [31:0] wd(input logic [31:0] a);
        return {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)};
    endfunction
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One idle cycle after each transfer keeps psel single-driven per step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 16)
        begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask
    task automatic wt(output logic [31:0] st);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000)
        begin
            failures++;
            tally_and_finish();
        end
        rd(`HMSL_A_STATUS, st);
    endtask
    task automatic run(input logic [31:0] ins, output logic [31:0] st);
        wr(`HMSL_A_INSTR, ins);
        wt(st);
    endtask
    task automatic t_half();
        logic [31:0] ops [9] = '{`HMSL_OP_LHA, `HMSL_OP_LHAU, `HMSL_OP_LHZ,
            `HMSL_OP_LHZU, `HMSL_OP_LHAX, `HMSL_OP_LHAUX, `HMSL_OP_LHZX,
            `HMSL_OP_LHZUX, `HMSL_OP_LHBRX};
        // Flags: indexed, update, signed, reversed, base field zero
        logic [4:0]  fl [9] = '{5'b00100, 5'b01100, 5'b00000, 5'b01000,
            5'b10100, 5'b11100, 5'b10001, 5'b11000, 5'b10010};
        logic [31:0] eff, q, st;
        logic [15:0] h;
        for (int k = 0; k < 9; k++)
        begin
            slow <= k[0];
            wr(8'h8c, 32'h0000_1000);
            wr(8'h90, 32'h0000_0035);
            eff = (fl[k][0] ? 32'h0 : 32'h1000) + (fl[k][4] ? 32'h35 : 32'h7);
            run(ops[k] | 32'h00a0_0000 | (fl[k][0] ? 32'h0 : 32'h0003_0000)
                | (fl[k][4] ? 32'h2000 : 32'h7), st);
            h = fl[k][1] ? {mb(eff + 1), mb(eff)} : {mb(eff), mb(eff + 1)};
            rd(8'h94, q);
            `CHK(q, {{16{fl[k][2] & h[15]}}, h})
            rd(8'h8c, q);
            `CHK(q, fl[k][3] ? eff : 32'h1000)
            rd(8'h10, q);
            `CHK(q, eff)
            rd(8'h90, q);
            `CHK(q, 32'h0000_0035)
        end
        wr(8'h94, 32'h0000_5555);
        run(`HMSL_OP_LHZU | 32'h00a5_0007, st);
        `CHK(st[`HMSL_ST_INVAL], 1'b1)
        run(`HMSL_OP_LHAUX | 32'h00a0_2000, st);
        `CHK(st[`HMSL_ST_INVAL], 1'b1)
        rd(8'h94, q);
        `CHK(q, 32'h0000_5555)
        $display("half loads done");
    endtask
    task automatic t_lmw();
        logic [31:0] q, st;
        wr(8'h88, 32'h0000_0040);
        run(`HMSL_OP_LMW | 32'h03a2_0000, st);
        for (int i = 0; i < 3; i++)
        begin
            rd(8'hf4 + 8'(4 * i), q);
            `CHK(q, wd(32'h40 + 4 * i))
        end
        wr(8'h88, 32'h0000_0042);
        run(`HMSL_OP_LMW | 32'h03a2_0000, st);
        `CHK(st[`HMSL_ST_ALIGN], 1'b1)
        rd(`HMSL_A_EXC, q);
        `CHK(q, 32'h0000_0300)
        rd(8'hf4, q);
        `CHK(q, wd(32'h40))
        run(`HMSL_OP_LMW | 32'h03be_0000, st);
        `CHK(st[`HMSL_ST_INVAL], 1'b1)
        $display("load multiple done");
    endtask
    task automatic t_str();
        logic [31:0] q, st;
        wr(8'h88, 32'h0000_0060);
        wr(8'hc8, 32'h0000_1234);
        run(`HMSL_OP_LSWI | 32'h03e2_3000, st);
        rd(8'hfc, q);
        `CHK(q, wd(32'h60))
        rd(8'h80, q);
        `CHK(q, {mb(32'h64), mb(32'h65), 16'h0000})
        run(`HMSL_OP_LSWI | 32'h0142_0000, st);
        rd(8'hc4, q);
        `CHK(q, wd(32'h7c))
        rd(8'hc8, q);
        `CHK(q, 32'h0000_1234)
        // Second byte ends a segment: abort, partial register untouched
        wr(8'ha4, 32'h0fff_fffe);
        run(`HMSL_OP_LSWI | 32'h0149_2000, st);
        `CHK(st[`HMSL_ST_ALIGN], 1'b1)
        rd(8'ha8, q);
        `CHK(q, wd(32'h60))
        run(`HMSL_OP_LSWI | 32'h03df_4000, st);
        `CHK(st[`HMSL_ST_INVAL], 1'b1)
        $display("immediate string done");
    endtask
    task automatic t_idx();
        logic [31:0] q, st;
        wr(8'h08, 32'h0000_0005);
        run(`HMSL_OP_LSWX | 32'h0282_2000, st);
        rd(8'hd0, q);
        `CHK(q, wd(32'h95))
        rd(8'hd4, q);
        `CHK(q, {mb(32'h99), 24'h00_0000})
        rd(8'h08, q);
        `CHK(q, 32'h0000_0005)
        run(`HMSL_OP_LSWX | 32'h0082_2000, st);
        `CHK(st[`HMSL_ST_INVAL], 1'b1)
        wr(8'h08, 32'h0000_0000);
        wr(8'hd0, 32'h0000_7777);
        run(`HMSL_OP_LSWX | 32'h0282_2000, st);
        rd(8'hd0, q);
        `CHK(q, 32'h0000_7777)
        $display("indexed string done");
    endtask
    task automatic t_bus();
        logic [31:0] q, st;
        logic        e;
        slow <= 1'b1;
        wr(`HMSL_A_INSTR, `HMSL_OP_LSWI | 32'h0142_0000);
        apb(1'b1, 8'hc8, 32'h0000_0009, q, e);
        `CHK(e, 1'b1)
        wt(st);
        rd(8'hc8, q);
        `CHK(q, 32'h0000_1234)
        apb(1'b0, 8'h14, 32'h0000_0000, q, e);
        `CHK({e, q}, 33'h1_0000_0000)
        apb(1'b1, `HMSL_A_STATUS, 32'h0000_000f, q, e);
        `CHK(e, 1'b1)
        $display("bus access done");
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_half();
        t_lmw();
        t_str();
        t_idx();
        t_bus();
        tally_and_finish();
    end
endmodule // tb_top
